// file: design/pfm_top.sv
// Pad function multiplexer, pad cell settings and pad interrupt unit.
// Assumes peripherals drive out/oe per function slot and pins may change at any time relative to clock.
//
// What this block does
// - Each pad has a 2-bit function select, reset to normal function.
// - Select 01 routes every pad to its own GPIO port bit.
// - Follow the function map; unlisted slots leave the pad unconnected; PC12-15 analog on normal select, PC8-15 on select 11.
// - Every pad input reaches the interrupt logic whatever function is selected.
// - Each pad has its own interrupt enable and polarity bit.
// - Interrupt enables reset to disabled.
// - Polarity resets to high-level sense; software may pick low-level.
// - Pad request is enable AND (polarity XOR pad level).
// - Combined interrupt is the OR of all pad requests.
// - Pull-up, pull-down, drive, input enable and buffer type per pad.
// - Core input follows pad with buffer on; buffer off in output mode reads 0.
// - One bit per pad picks CMOS or Schmitt input buffer.
// - Drive select 1 is high drive, 0 is low drive.
// - Separate pull-down and pull-up enables go to the pad cell.
// - Each pad's function select lives in its own register.
`include "pfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Settings write port
  input wire logic cfg_we,
  input wire logic [`PFM_PAD_W-1:0] cfg_pad,
  input wire pfm_cfg_s cfg_wdata,
  // Settings read port
  input wire logic [`PFM_PAD_W-1:0] cfg_rd_pad,
  output pfm_cfg_s cfg_rd_data,
  // Peripheral side, one row per selection slot
  input wire logic [`PFM_NSLOT-1:0][`PFM_NPADS-1:0] fn_out,
  input wire logic [`PFM_NSLOT-1:0][`PFM_NPADS-1:0] fn_oe,
  output logic [`PFM_NSLOT-1:0][`PFM_NPADS-1:0] fn_in,
  output logic [`PFM_NAIN-1:0] analog_input_sel,
  // Pad side
  input wire logic [`PFM_NPADS-1:0] pad_in,
  output logic [`PFM_NPADS-1:0] pad_out,
  output logic [`PFM_NPADS-1:0] pad_oe,
  output pfm_pad_cell_control_s [`PFM_NPADS-1:0] pad_cell_control,
  // Interrupts
  output logic [`PFM_NPADS-1:0] pad_irq_req,
  output logic combined_pad_irq
);

  localparam int NP = `PFM_NPADS;
  localparam logic [15:0] ANA_NORMAL_C = `PFM_ANA_SLOT0_C;
  localparam logic [15:0] ANA_FOURTH_C = `PFM_ANA_SLOT3_C;
  localparam pfm_cfg_s CFG_RST = '{
    fsel: PFM_FN_NORMAL,
    input_buffer_on: `PFM_RST_IBUF,
    schmitt_sel: `PFM_RST_SCHMITT,
    weak_high_bias: `PFM_RST_PULLUP,
    weak_low_bias: `PFM_RST_PULLDN,
    drive_strength_sel: `PFM_RST_DRIVE,
    irq_enable: `PFM_RST_IRQ_EN,
    irq_falling: `PFM_RST_IRQ_FALL
  };

  // Digital functions of each pad, bit n set when selection value n has one.
  // Kept pad by pad so the map reads line against line with the pin list;
  // a value whose only function is analog carries no bit.
  function automatic logic [3:0] port_a_slots(input logic [3:0] b);
    unique case (b)
      4'h0: port_a_slots = 4'h7;
      4'h1: port_a_slots = 4'h7;
      4'h2: port_a_slots = 4'h7;
      4'h3: port_a_slots = 4'h3;
      4'h4: port_a_slots = 4'h3;
      4'h5: port_a_slots = 4'hF;
      4'h6: port_a_slots = 4'hF;
      4'h7: port_a_slots = 4'hF;
      4'h8: port_a_slots = 4'hF;
      4'h9: port_a_slots = 4'hF;
      4'hA: port_a_slots = 4'hF;
      4'hB: port_a_slots = 4'h7;
      4'hC: port_a_slots = 4'h7;
      4'hD: port_a_slots = 4'h7;
      4'hE: port_a_slots = 4'h7;
      4'hF: port_a_slots = 4'h3;
    endcase
  endfunction

  function automatic logic [3:0] port_b_slots(input logic [3:0] b);
    unique case (b)
      4'h0: port_b_slots = 4'h7;
      4'h1: port_b_slots = 4'h7;
      4'h2: port_b_slots = 4'h7;
      4'h3: port_b_slots = 4'h7;
      4'h4: port_b_slots = 4'h3;
      4'h5: port_b_slots = 4'h3;
      4'h6: port_b_slots = 4'h3;
      4'h7: port_b_slots = 4'h3;
      4'h8: port_b_slots = 4'h3;
      4'h9: port_b_slots = 4'h3;
      4'hA: port_b_slots = 4'h3;
      4'hB: port_b_slots = 4'h3;
      4'hC: port_b_slots = 4'h3;
      4'hD: port_b_slots = 4'h3;
      4'hE: port_b_slots = 4'h2;
      4'hF: port_b_slots = 4'h2;
    endcase
  endfunction

  function automatic logic [3:0] port_c_slots(input logic [3:0] b);
    unique case (b)
      4'h0: port_c_slots = 4'h7;
      4'h1: port_c_slots = 4'h7;
      4'h2: port_c_slots = 4'h7;
      4'h3: port_c_slots = 4'h7;
      4'h4: port_c_slots = 4'h7;
      4'h5: port_c_slots = 4'h7;
      4'h6: port_c_slots = 4'h7;
      4'h7: port_c_slots = 4'h7;
      4'h8: port_c_slots = 4'h7;
      4'h9: port_c_slots = 4'h7;
      4'hA: port_c_slots = 4'h7;
      4'hB: port_c_slots = 4'h7;
      4'hC: port_c_slots = 4'h6;
      4'hD: port_c_slots = 4'h6;
      4'hE: port_c_slots = 4'h6;
      4'hF: port_c_slots = 4'h6;
    endcase
  endfunction

  function automatic logic [3:0] port_d_slots(input logic [3:0] b);
    unique case (b)
      4'h0: port_d_slots = 4'h3;
      4'h1: port_d_slots = 4'h3;
      4'h2: port_d_slots = 4'h3;
      4'h3: port_d_slots = 4'h3;
      4'h4: port_d_slots = 4'h3;
      default: port_d_slots = 4'h0;
    endcase
  endfunction

  // Port letter and bit of a pad index decide which map is consulted
  function automatic logic [3:0] pad_slots(input int p);
    logic [1:0] port;
    logic [3:0] bit_idx;
    port = 2'(p >> 4);
    bit_idx = 4'(p);
    unique case (port)
      2'h0: pad_slots = port_a_slots(bit_idx);
      2'h1: pad_slots = port_b_slots(bit_idx);
      2'h2: pad_slots = port_c_slots(bit_idx);
      2'h3: pad_slots = port_d_slots(bit_idx);
    endcase
  endfunction

  // Index decode shared by the write and the read port.
  // Indices past the last pad are holes: writes vanish, reads give zero.
  function automatic logic pad_exists(input logic [`PFM_PAD_W-1:0] idx);
    pad_exists = int'(idx) < NP;
  endfunction

  // Pad index behind each analog channel, top of port C first
  function automatic int ain_pad(input logic [2:0] k);
    unique case (k)
      3'h0: ain_pad = 6'h2F;
      3'h1: ain_pad = 6'h2E;
      3'h2: ain_pad = 6'h2D;
      3'h3: ain_pad = 6'h2C;
      3'h4: ain_pad = 6'h2B;
      3'h5: ain_pad = 6'h2A;
      3'h6: ain_pad = 6'h29;
      3'h7: ain_pad = 6'h28;
    endcase
  endfunction

  // True when the selection value has a digital function on this pad
  function automatic logic fn_avail(input pfm_fsel_e s, input int p);
    logic [3:0] slots;
    slots = pad_slots(p);
    fn_avail = slots[s];
  endfunction

  // True when the selection value turns this pad into an analog input
  function automatic logic ana_sel(input pfm_fsel_e s, input int p);
    logic on_port_c;
    logic [3:0] c;
    on_port_c = (p >= int'(`PFM_PORT_C)) && (p < int'(`PFM_PORT_D));
    c = 4'(p - int'(`PFM_PORT_C));
    unique case (s)
      PFM_FN_NORMAL: ana_sel = on_port_c && ANA_NORMAL_C[c];
      PFM_FN_GPIO: ana_sel = 1'b0;
      PFM_FN_THIRD: ana_sel = 1'b0;
      PFM_FN_FOURTH: ana_sel = on_port_c && ANA_FOURTH_C[c];
    endcase
  endfunction

  pfm_cfg_s [NP-1:0] cfg;
  pfm_cfg_s [NP-1:0] next_cfg;
  pfm_cfg_s next_cfg_rd_data;
  logic [NP-1:0] pad_sync;
  logic [NP-1:0] next_pad_irq_req;
  logic [NP-1:0] pad_digital;
  logic [NP-1:0] pad_analog;

  // Per-pad decode of the current selection. An analog selection gives no
  // digital route, so the pad cell never fights the converter input.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pad_digital[p] = fn_avail(cfg[p].fsel, p);
      pad_analog[p] = ana_sel(cfg[p].fsel, p);
    end
  end

  // Settings registers, one word per pad; writes to missing pads are dropped
  always_comb begin
    next_cfg = cfg;
    if (cfg_we && pad_exists(cfg_pad)) begin
      next_cfg[cfg_pad] = cfg_wdata;
    end
    next_cfg_rd_data = '0;
    if (pad_exists(cfg_rd_pad)) begin
      next_cfg_rd_data = cfg[cfg_rd_pad];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NP; p++) begin
        cfg[p] <= CFG_RST;
      end
      cfg_rd_data <= '0;
    end else begin
      cfg <= next_cfg;
      cfg_rd_data <= next_cfg_rd_data;
    end
  end

  // Pad cell controls come straight from the settings flops
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pad_cell_control[p].input_buffer_on = cfg[p].input_buffer_on;
      pad_cell_control[p].schmitt_sel = cfg[p].schmitt_sel;
      pad_cell_control[p].weak_high_bias = cfg[p].weak_high_bias;
      pad_cell_control[p].weak_low_bias = cfg[p].weak_low_bias;
      pad_cell_control[p].drive_strength_sel = cfg[p].drive_strength_sel;
    end
  end

  // Routing. Kept combinational so peripheral timing is not stretched by a cycle.
  always_comb begin
    fn_in = '0;
    for (int p = 0; p < NP; p++) begin
      pad_out[p] = 1'b0;
      pad_oe[p] = 1'b0;
      if (pad_digital[p]) begin
        // Slot 1 rows are the GPIO port bits at the same port and index
        pad_out[p] = fn_out[cfg[p].fsel][p];
        pad_oe[p] = fn_oe[cfg[p].fsel][p];
        if (cfg[p].input_buffer_on || !fn_oe[cfg[p].fsel][p]) begin
          fn_in[cfg[p].fsel][p] = pad_in[p];
        end
      end
    end
  end

  // Analog channel k sits on port C pad 15-k
  always_comb begin
    for (int k = 0; k < `PFM_NAIN; k++) begin
      analog_input_sel[k] = pad_analog[ain_pad(3'(k))];
    end
  end

  // Raw pad levels, before any function routing, feed the interrupt unit
  pfm_sync #(
    .W(NP)
  ) u_pad_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(pad_in),
    .q(pad_sync)
  );

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      next_pad_irq_req[p] = cfg[p].irq_enable & (cfg[p].irq_falling ^ pad_sync[p]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_irq_req <= '0;
    end else begin
      pad_irq_req <= next_pad_irq_req;
    end
  end

  assign combined_pad_irq = |pad_irq_req;

endmodule
`default_nettype wire

// file: design/pfm_params.svh
// Constants for the pad function mux and pad interrupt unit.
// Assumes pads are numbered port A 0..15, B 16..31, C 32..47, D 48..52.
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH

`define PFM_NPADS 53
`define PFM_PAD_W 6
`define PFM_NAIN 8
`define PFM_NSLOT 4

// Port base indices
`define PFM_PORT_A 6'h00
`define PFM_PORT_B 6'h10
`define PFM_PORT_C 6'h20
`define PFM_PORT_D 6'h30

// Pads with a digital function per selection value, bit = pad index {D,C,B,A}
`define PFM_SLOT0_MASK {5'h1F, 16'h0FFF, 16'h3FFF, 16'hFFFF}
`define PFM_SLOT1_MASK {5'h1F, 16'hFFFF, 16'hFFFF, 16'hFFFF}
`define PFM_SLOT2_MASK {5'h00, 16'hFFFF, 16'h000F, 16'h7FE7}
`define PFM_SLOT3_MASK {5'h00, 16'h0000, 16'h0000, 16'h07E0}

// Port C pads that turn analog on the normal and the fourth selection
`define PFM_ANA_SLOT0_C 16'hF000
`define PFM_ANA_SLOT3_C 16'hFF00
`define PFM_ANA_TOP_PAD 4'hF

// Reset values of the per-pad settings
`define PFM_RST_IBUF 1'b1
`define PFM_RST_SCHMITT 1'b0
`define PFM_RST_PULLUP 1'b0
`define PFM_RST_PULLDN 1'b0
`define PFM_RST_DRIVE 1'b0
`define PFM_RST_IRQ_EN 1'b0
`define PFM_RST_IRQ_FALL 1'b0

`endif

// file: design/pfm_pkg.sv
// Types for the pad function mux and pad interrupt unit.
// Assumes pfm_params.svh is on the include path.
package pfm_pkg;

  typedef enum logic [1:0] {
    PFM_FN_NORMAL,
    PFM_FN_GPIO,
    PFM_FN_THIRD,
    PFM_FN_FOURTH
  } pfm_fsel_e;

  // One pad's software settings
  typedef struct packed {
    pfm_fsel_e fsel;
    logic input_buffer_on;
    logic schmitt_sel;
    logic weak_high_bias;
    logic weak_low_bias;
    logic drive_strength_sel;
    logic irq_enable;
    logic irq_falling;
  } pfm_cfg_s;

  // What the pad cell itself sees
  typedef struct packed {
    logic input_buffer_on;
    logic schmitt_sel;
    logic weak_high_bias;
    logic weak_low_bias;
    logic drive_strength_sel;
  } pfm_pad_cell_control_s;

endpackage

// file: design/pfm_sync.sv
// Two-stage level synchroniser, one per bit.
// Assumes the inputs may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// file: verif/pfm_pad_model.sv
// Far side of the pads: board level wherever no pad drives.
// Assumes ext is the level the board would show.
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_model (
  // Pad cell and board
  input wire logic [52:0] pad_out,
  input wire logic [52:0] pad_oe,
  input wire logic [52:0] ext,
  // To the core
  output logic [52:0] pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule
`default_nettype wire

// file: verif/pfm_top_sva.sv
// Port checker for pfm_top.
// Assumes the bind below and pfm_params.svh on the include path.
`include "pfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfm_top_sva import pfm_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Settings
  input wire logic cfg_we,
  input wire logic [5:0] cfg_pad,
  input wire pfm_cfg_s cfg_wdata,
  input wire pfm_cfg_s cfg_rd_data,
  // Pads
  input wire logic [3:0][52:0] fn_oe,
  input wire logic [3:0][52:0] fn_in,
  input wire logic [52:0] pad_in,
  input wire logic [52:0] pad_oe,
  input wire pfm_pad_cell_control_s [52:0] pad_cell_control,
  input wire logic [52:0] pad_irq_req,
  input wire logic combined_pad_irq
);
  localparam logic [52:0] M3 = `PFM_SLOT3_MASK;
  logic wv;
  logic [5:0] wp;
  pfm_cfg_s wd;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Last accepted write, so pad cell control, pad_oe and fn_in can be tied to it a cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) wv <= 1'b0;
    else wv <= cfg_we && cfg_pad < 6'h35;
  end
  always_ff @(posedge clock) {wp, wd} <= {cfg_pad, cfg_wdata};
  sequence s_en0; cfg_we && cfg_pad == 6'h00 && cfg_wdata[1:0] == 2'h2; endsequence
  sequence s_hi0; (!(cfg_we && cfg_pad == 6'h00) && pad_in[0])[*3]; endsequence
  property p_rst; $rose(rst_n) |=> cfg_rd_data == 9'h040; endproperty
  a_rst: assert property (p_rst) else $error("reset settings");
  property p_cell; wv |-> pad_cell_control[wp] == wd[6:2]; endproperty
  a_cell: assert property (p_cell) else $error("cell control");
  property p_gpio; wv && wd.fsel == PFM_FN_GPIO |-> pad_oe[wp] == fn_oe[1][wp]; endproperty
  a_gpio: assert property (p_gpio) else $error("gpio route");
  property p_fnin; wv && wd.fsel == PFM_FN_GPIO |->
    fn_in[1][wp] == (pad_in[wp] & (wd.input_buffer_on | !fn_oe[1][wp])); endproperty
  a_fnin: assert property (p_fnin) else $error("core input");
  property p_open; wv && wd.fsel == PFM_FN_FOURTH && !M3[wp] |->
    !pad_oe[wp] && !fn_in[3][wp]; endproperty
  a_open: assert property (p_open) else $error("open slot");
  property p_irq_on; s_en0 ##1 s_hi0 |=> pad_irq_req[0]; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off; cfg_we && cfg_pad == 6'h00 && !cfg_wdata.irq_enable ##1
    !(cfg_we && cfg_pad == 6'h00) |=> !pad_irq_req[0]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq masked");
  property p_any; combined_pad_irq == |pad_irq_req; endproperty
  a_any: assert property (p_any) else $error("combined irq");
endmodule
bind pfm_top pfm_top_sva chk (.clock, .rst_n, .cfg_we, .cfg_pad, .cfg_wdata, .cfg_rd_data,
  .fn_oe, .fn_in, .pad_in, .pad_oe, .pad_cell_control, .pad_irq_req, .combined_pad_irq);
`default_nettype wire

// file: verif/pad_function_mux_and_ext_irq_test.sv
// Random and corner tests of pfm_top; a shadow of the settings predicts outputs.
// Assumes design/ on the include path.
`include "pfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module pad_function_mux_and_ext_irq_test import pfm_pkg::*;;
  logic clock = 1'b0;
  logic rst_n, cfg_we, combined_pad_irq;
  logic [5:0] cfg_pad, cfg_rd_pad, p;
  logic [8:0] d;
  pfm_cfg_s cfg_wdata, cfg_rd_data;
  logic [3:0][52:0] fn_out, fn_oe, fn_in;
  logic [7:0] analog_input_sel;
  logic [52:0] pad_in, pad_out, pad_oe, pad_irq_req, ext;
  pfm_pad_cell_control_s [52:0] pad_cell_control;
  pfm_cfg_s sh [53];
  int seed = 52181, mismatches = 0, n_checks = 0;
  localparam logic [3:0][52:0] M = {`PFM_SLOT3_MASK, `PFM_SLOT2_MASK, `PFM_SLOT1_MASK,
    `PFM_SLOT0_MASK};
  always #5 clock = ~clock;
  pfm_top dut (.clock, .rst_n, .cfg_we, .cfg_pad, .cfg_wdata, .cfg_rd_pad, .cfg_rd_data,
    .fn_out, .fn_oe, .fn_in, .analog_input_sel, .pad_in, .pad_out, .pad_oe,
    .pad_cell_control, .pad_irq_req, .combined_pad_irq);
  pfm_pad_model far_side (.pad_out, .pad_oe, .ext, .pad_in);
  function automatic logic [52:0] r53();
    return 53'({$random(seed), $random(seed)});
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_all(input logic [5:0] r);
    logic [52:0] oe = '0, ou = '0, ir = '0;
    logic [3:0][52:0] fi = '0;
    logic [7:0] an = '0;
    pfm_pad_cell_control_s [52:0] pc;
    pfm_fsel_e f;
    for (int q = 0; q < 53; q++) begin
      f = sh[q].fsel;
      if (q > 39 && q < 48 && (f == PFM_FN_FOURTH || (f == PFM_FN_NORMAL && q > 43))) begin
        an[47 - q] = 1'b1;
      end
      // Analog pads get no digital drive, whatever the slot mask says
      if (M[f][q] && an[(47 - q) % 8] !== 1'b1 || q < 40 || q > 47) begin
        if (M[f][q]) begin
          oe[q] = fn_oe[f][q];
          ou[q] = fn_out[f][q];
          fi[f][q] = pad_in[q] & (sh[q].input_buffer_on | !fn_oe[f][q]);
        end
      end
      pc[q] = sh[q][6:2];
      ir[q] = sh[q].irq_enable & (sh[q].irq_falling ^ pad_in[q]);
    end
    `CHK(pad_oe, oe)
    `CHK(pad_out, ou)
    `CHK(fn_in, fi)
    `CHK(analog_input_sel, an)
    `CHK(pad_cell_control, pc)
    `CHK(pad_irq_req, ir)
    `CHK(combined_pad_irq, |ir)
    `CHK(cfg_rd_data, r < 6'h35 ? sh[r] : pfm_cfg_s'(9'h000))
  endtask
  initial begin
    {rst_n, cfg_we, cfg_pad, cfg_rd_pad, cfg_wdata, fn_out, fn_oe, ext} = '0;
    for (int q = 0; q < 53; q++) sh[q] = 9'h040;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    for (int q = 0; q < 64; q++) begin
      cfg_rd_pad = 6'(q);
      @(posedge clock);
      #1 chk_all(cfg_rd_pad);
    end
    for (int i = 0; i < 300; i++) begin
      // Pad 0 is armed then masked while the board holds it high
      p = i < 2 ? 6'h00 : 6'($random(seed));
      d = i == 0 ? 9'h182 : i == 1 ? 9'h180 : 9'($random(seed));
      for (int s = 0; s < 4; s++) begin
        fn_out[s] = r53();
        fn_oe[s] = r53();
      end
      ext = i < 2 ? '1 : r53();
      {cfg_we, cfg_pad, cfg_rd_pad, cfg_wdata} = {1'b1, p, p, d};
      if (p < 6'h35) sh[p] = d;
      @(posedge clock);
      #1 cfg_we = 1'b0;
      repeat (4) @(posedge clock);
      #1 chk_all(p);
    end
    summarize();
  end
  initial begin
    // The run needs about 1600 cycles
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
